/* File: common/ags_pkg.sv */
// constants for the graphics port grant-status and request-enqueue block
// assumes a link clock for the port and a separate core clock
package ags_pkg;
	// widths of the port lines
	localparam int ADDR_W = 32;
	localparam int CMD_W = 4;
	localparam int SB_W = 8;
	localparam int CNT_W = 16;
	// request queue shape
	localparam int QDEPTH = 8;
	localparam int QPTR_W = 3;
	localparam logic [3:0] QFULL = 4'h8;
	localparam logic [3:0] QEMPTY = 4'h0;
	// data beats in one serviced transfer
	localparam logic [1:0] LAST_BEAT = 2'h3;
	// status codes shown with the grant
	typedef enum logic [2:0] {
		ST_LO_READ = 3'b000,
		ST_HI_READ = 3'b001,
		ST_LO_WRITE = 3'b010,
		ST_HI_WRITE = 3'b011,
		ST_START = 3'b111
	} ags_status_type;
	localparam logic [2:0] ST_RSVD_LO = 3'h4;
	localparam logic [2:0] ST_RSVD_HI = 3'h6;
	// request commands carried on the command lines
	localparam logic [3:0] CMD_RD_LO = 4'h0;
	localparam logic [3:0] CMD_RD_HI = 4'h1;
	localparam logic [3:0] CMD_WR_LO = 4'h2;
	localparam logic [3:0] CMD_WR_HI = 4'h3;
	// command lines driven while read data returns
	localparam logic [3:0] CBE_READ = 4'h0;
	// sideband byte layout: command high nibble, line index low nibble
	localparam int SB_CMD_LSB = 4;
	localparam int SB_IDX_W = 4;
	localparam int LINE_SHIFT = 3;
	// arbiter states
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_OPEN = 2'b01,
		S_SERVE = 2'b10
	} ags_state_type;
endpackage : ags_pkg

/* File: src/ags_sync2.sv */
// two-flop level synchroniser
// assumes the input is a level that stays put for several destination clocks
`timescale 1ns/1ps
module ags_sync2 (
	// destination clock
	input wire logic clk,
	// level in and synchronised level out
	input wire logic d,
	output logic q
);
	logic meta_q;

	// first flop is read only by the second
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule : ags_sync2

/* File: src/ags_grant_port.sv */
// grant-status arbiter and request queue for the graphics port target
// assumes port pins are synchronous to port_clk; core controls on clock
`timescale 1ns/1ps

module ags_grant_port (
	// core clock and reset
	input wire logic clock,
	input wire logic rst,
	// core controls and counters
	input wire logic sideband_enable,
	input wire logic transfer_2x_mode,
	output logic [15:0] enqueued_count,
	output logic [15:0] serviced_count,
	// link clock
	input wire logic port_clk,
	// arbitration
	output logic port_grant_n,
	output logic [2:0] grant_status_code,
	input wire logic port_bus_request_n,
	input wire logic pipelined_request_n,
	input wire logic read_buffer_full_n,
	// sideband request port
	input wire logic [7:0] sideband_request_port,
	input wire logic sideband_strobe,
	// address/data lines
	input wire logic [31:0] port_addr_data_i,
	output logic [31:0] port_addr_data_o,
	output logic port_addr_data_oe,
	// command / byte enable lines
	input wire logic [3:0] port_cmd_byte_en_n_i,
	output logic [3:0] port_cmd_byte_en_n_o,
	output logic port_cmd_byte_en_n_oe,
	// ready handshake
	input wire logic port_initiator_ready_n,
	output logic port_target_ready_n_o,
	output logic port_target_ready_n_oe,
	// 2X data strobes
	output logic low_lane_data_strobe_o,
	output logic low_lane_data_strobe_oe,
	output logic high_lane_data_strobe_o,
	output logic high_lane_data_strobe_oe,
	// link status
	output logic [31:0] last_write_data,
	output logic queue_overflow
);
	////////////////////////////////////////////////////////////////////////
	// crossings
	logic port_rst, sb_en, x2_mode;
	logic enq_tgl_q, srv_tgl_q, enq_tgl_c, srv_tgl_c, enq_prev_q, srv_prev_q;

	// reset and core levels into the link domain
	ags_sync2 u_rst (.clk(port_clk), .d(rst), .q(port_rst));
	ags_sync2 u_sben (.clk(port_clk), .d(sideband_enable), .q(sb_en));
	ags_sync2 u_x2 (.clk(port_clk), .d(transfer_2x_mode), .q(x2_mode));
	// link event toggles into the core domain
	ags_sync2 u_enq (.clk(clock), .d(enq_tgl_q), .q(enq_tgl_c));
	ags_sync2 u_srv (.clk(clock), .d(srv_tgl_q), .q(srv_tgl_c));

	// core counters advance on each toggle edge
	always_ff @(posedge clock) begin
		if (rst) begin
			enq_prev_q <= 1'b0;
			srv_prev_q <= 1'b0;
			enqueued_count <= 16'h0000;
			serviced_count <= 16'h0000;
		end else begin
			enq_prev_q <= enq_tgl_c;
			srv_prev_q <= srv_tgl_c;
			if (enq_tgl_c != enq_prev_q)
				enqueued_count <= enqueued_count + 16'h0001;
			if (srv_tgl_c != srv_prev_q)
				serviced_count <= serviced_count + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request queue
	logic [3:0] cmd_mem [ags_pkg::QDEPTH];
	logic [31:0] addr_mem [ags_pkg::QDEPTH];
	logic [2:0] wr_ptr_q, rd_ptr_q;
	logic [3:0] count_q;
	logic sb_strobe_q, sb_rise, pipe_take, sb_take, enq, done;
	logic [3:0] enq_cmd, head_cmd;
	logic [31:0] enq_addr, head_addr;
	ags_pkg::ags_state_type state_q;
	logic [1:0] beat_q;

	// requests from the pipelined strobe or the sideband port
	assign sb_rise = sb_en && sideband_strobe && !sb_strobe_q;
	assign pipe_take = state_q == ags_pkg::S_OPEN && !pipelined_request_n;
	assign sb_take = sb_rise && !pipe_take;
	assign enq = (pipe_take || sb_take) && count_q != ags_pkg::QFULL;
	assign enq_cmd = pipe_take ? port_cmd_byte_en_n_i :
		sideband_request_port[ags_pkg::SB_CMD_LSB +: ags_pkg::CMD_W];
	assign enq_addr = pipe_take ? port_addr_data_i :
		32'(sideband_request_port[ags_pkg::SB_IDX_W-1:0]) << ags_pkg::LINE_SHIFT;
	assign head_cmd = cmd_mem[rd_ptr_q];
	assign head_addr = addr_mem[rd_ptr_q];

	// storage written in arrival order
	always_ff @(posedge port_clk) begin
		if (enq) begin
			cmd_mem[wr_ptr_q] <= enq_cmd;
			addr_mem[wr_ptr_q] <= enq_addr;
		end
	end

	// pointers, fill level, event toggles and overflow flag
	always_ff @(posedge port_clk) begin
		if (port_rst) begin
			wr_ptr_q <= 3'h0;
			rd_ptr_q <= 3'h0;
			count_q <= ags_pkg::QEMPTY;
			sb_strobe_q <= 1'b0;
			enq_tgl_q <= 1'b0;
			srv_tgl_q <= 1'b0;
			queue_overflow <= 1'b0;
		end else begin
			sb_strobe_q <= sideband_strobe;
			if (enq) begin
				wr_ptr_q <= wr_ptr_q + 3'h1;
				enq_tgl_q <= !enq_tgl_q;
			end
			if (done) begin
				rd_ptr_q <= rd_ptr_q + 3'h1;
				srv_tgl_q <= !srv_tgl_q;
			end
			if (enq && !done)
				count_q <= count_q + 4'h1;
			else if (done && !enq)
				count_q <= count_q - 4'h1;
			if ((pipe_take || sb_take) && count_q == ags_pkg::QFULL)
				queue_overflow <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arbiter
	logic [2:0] head_code;
	logic head_wr, head_ok, xfer_go, rd_beat;

	// status code belonging to the oldest request
	always_comb begin
		unique case (head_cmd)
			ags_pkg::CMD_RD_HI: head_code = ags_pkg::ST_HI_READ;
			ags_pkg::CMD_WR_LO: head_code = ags_pkg::ST_LO_WRITE;
			ags_pkg::CMD_WR_HI: head_code = ags_pkg::ST_HI_WRITE;
			default: head_code = ags_pkg::ST_LO_READ;
		endcase
	end

	// a low read waits while the master's read buffer is full
	assign head_wr = head_code == ags_pkg::ST_LO_WRITE || head_code == ags_pkg::ST_HI_WRITE;
	assign head_ok = count_q != ags_pkg::QEMPTY &&
		!(head_code == ags_pkg::ST_LO_READ && !read_buffer_full_n);
	// writes start on initiator ready, then run without waits
	assign xfer_go = state_q == ags_pkg::S_SERVE &&
		(!head_wr || !port_initiator_ready_n || beat_q != 2'h0);
	assign done = xfer_go && beat_q == ags_pkg::LAST_BEAT;
	assign rd_beat = state_q == ags_pkg::S_SERVE && !head_wr;

	// state, grant and status; status only changes when a grant begins
	always_ff @(posedge port_clk) begin
		if (port_rst) begin
			state_q <= ags_pkg::S_IDLE;
			port_grant_n <= 1'b1;
			grant_status_code <= ags_pkg::ST_START;
		end else begin
			unique case (state_q)
				ags_pkg::S_IDLE: begin
					if (head_ok) begin
						state_q <= ags_pkg::S_SERVE;
						port_grant_n <= 1'b0;
						grant_status_code <= head_code;
					end else if (!port_bus_request_n) begin
						state_q <= ags_pkg::S_OPEN;
						port_grant_n <= 1'b0;
						grant_status_code <= ags_pkg::ST_START;
					end
				end
				ags_pkg::S_OPEN: begin
					if (port_bus_request_n && pipelined_request_n) begin
						state_q <= ags_pkg::S_IDLE;
						port_grant_n <= 1'b1;
					end
				end
				ags_pkg::S_SERVE: begin
					if (done) begin
						state_q <= ags_pkg::S_IDLE;
						port_grant_n <= 1'b1;
					end
				end
				default: begin
					state_q <= ags_pkg::S_IDLE;
					port_grant_n <= 1'b1;
				end
			endcase
		end
	end

	// beat counter of the serviced transfer
	always_ff @(posedge port_clk) begin
		if (port_rst)
			beat_q <= 2'h0;
		else if (done)
			beat_q <= 2'h0;
		else if (xfer_go)
			beat_q <= beat_q + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive
	// read data, command lines and target ready follow state by one clock
	always_ff @(posedge port_clk) begin
		if (port_rst) begin
			port_addr_data_o <= 32'h0000_0000;
			port_addr_data_oe <= 1'b0;
			port_cmd_byte_en_n_o <= ags_pkg::CBE_READ;
			port_cmd_byte_en_n_oe <= 1'b0;
			port_target_ready_n_o <= 1'b1;
			port_target_ready_n_oe <= 1'b0;
		end else begin
			port_addr_data_o <= head_addr + {30'h0, beat_q};
			port_addr_data_oe <= rd_beat;
			port_cmd_byte_en_n_o <= ags_pkg::CBE_READ;
			port_cmd_byte_en_n_oe <= rd_beat;
			port_target_ready_n_o <= !xfer_go;
			port_target_ready_n_oe <= state_q == ags_pkg::S_SERVE;
		end
	end

	// strobes toggle while the device supplies 2X read data
	always_ff @(posedge port_clk) begin
		if (port_rst) begin
			low_lane_data_strobe_o <= 1'b0;
			low_lane_data_strobe_oe <= 1'b0;
			high_lane_data_strobe_o <= 1'b0;
			high_lane_data_strobe_oe <= 1'b0;
		end else begin
			low_lane_data_strobe_oe <= rd_beat && x2_mode;
			high_lane_data_strobe_oe <= rd_beat && x2_mode;
			low_lane_data_strobe_o <= rd_beat && x2_mode && !low_lane_data_strobe_o;
			high_lane_data_strobe_o <= rd_beat && x2_mode && !high_lane_data_strobe_o;
		end
	end

	// capture write data as the master supplies it
	always_ff @(posedge port_clk) begin
		if (port_rst)
			last_write_data <= 32'h0000_0000;
		else if (xfer_go && head_wr)
			last_write_data <= port_addr_data_i;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge port_clk); endclocking
	default disable iff (rst || port_rst);

	property p_status_legal;
		grant_status_code < ags_pkg::ST_RSVD_LO || grant_status_code > ags_pkg::ST_RSVD_HI;
	endproperty
	a_status_legal: assert property (p_status_legal) else $error("reserved status");

	property p_open_start;
		state_q == ags_pkg::S_OPEN |-> !port_grant_n && grant_status_code == ags_pkg::ST_START;
	endproperty
	a_open_start: assert property (p_open_start) else $error("open without 111");

	property p_serve_code;
		state_q == ags_pkg::S_IDLE && head_ok |=>
			state_q == ags_pkg::S_SERVE && grant_status_code == $past(head_code);
	endproperty
	a_serve_code: assert property (p_serve_code) else $error("wrong serve code");

	property p_serve_stable;
		state_q == ags_pkg::S_SERVE ##1 state_q == ags_pkg::S_SERVE |->
			$stable(grant_status_code) && !port_grant_n;
	endproperty
	a_serve_stable: assert property (p_serve_stable) else $error("status moved");

	property p_rbf_block;
		state_q == ags_pkg::S_IDLE && count_q != ags_pkg::QEMPTY &&
			head_code == ags_pkg::ST_LO_READ && !read_buffer_full_n |=>
			state_q != ags_pkg::S_SERVE;
	endproperty
	a_rbf_block: assert property (p_rbf_block) else $error("low read while full");

	property p_pipe_enq;
		state_q == ags_pkg::S_OPEN && !pipelined_request_n && count_q != ags_pkg::QFULL
			|=> count_q == $past(count_q) + 4'h1;
	endproperty
	a_pipe_enq: assert property (p_pipe_enq) else $error("request not taken");

	property p_no_enq;
		(pipelined_request_n || state_q != ags_pkg::S_OPEN) && !sb_rise && !done
			|=> $stable(count_q);
	endproperty
	a_no_enq: assert property (p_no_enq) else $error("stray request");

	property p_sb_off;
		!sb_en && state_q == ags_pkg::S_IDLE |=> $stable(count_q);
	endproperty
	a_sb_off: assert property (p_sb_off) else $error("sideband used while off");

	property p_read_cbe;
		rd_beat |=> port_cmd_byte_en_n_oe && port_cmd_byte_en_n_o == ags_pkg::CBE_READ;
	endproperty
	a_read_cbe: assert property (p_read_cbe) else $error("command lines not 0000");

	property p_strobe_rd;
		rd_beat && x2_mode |=> low_lane_data_strobe_oe && high_lane_data_strobe_oe &&
			low_lane_data_strobe_o != $past(low_lane_data_strobe_o);
	endproperty
	a_strobe_rd: assert property (p_strobe_rd) else $error("strobe not driven");

	property p_strobe_wr;
		state_q == ags_pkg::S_SERVE && head_wr |=>
			!low_lane_data_strobe_oe && !high_lane_data_strobe_oe;
	endproperty
	a_strobe_wr: assert property (p_strobe_wr) else $error("strobe driven on write");

	property p_write_run;
		state_q == ags_pkg::S_SERVE && head_wr && !port_initiator_ready_n && beat_q == 2'h0
			|-> ##3 done;
	endproperty
	a_write_run: assert property (p_write_run) else $error("write not 4 beats");

	c_open_pipe: cover property (state_q == ags_pkg::S_OPEN && pipe_take);
	c_read_2x: cover property (rd_beat && x2_mode ##1 done);
	c_write_done: cover property (state_q == ags_pkg::S_SERVE && head_wr && done);
	c_sideband: cover property (sb_take && enq);
endmodule : ags_grant_port

/* File: testbench/ags_master_model.sv */
// graphics controller model acting as port master
// assumes grant and status change just after port_clk rising edges
`timescale 1ns/1ps
module ags_master_model (
	// link clock and reset
	input wire logic port_clk,
	input wire logic rst,
	// bench commands
	input wire logic go,
	input wire logic [3:0] n_req,
	input wire logic [31:0] base,
	input wire logic [31:0] cmd_pat,
	input wire logic [31:0] wbase,
	input wire logic [1:0] lat,
	input wire logic sb_go,
	input wire logic [7:0] sb_byte,
	// arbitration from the device
	input wire logic port_grant_n,
	input wire logic [2:0] grant_status_code,
	// master pins
	output logic port_bus_request_n,
	output logic pipelined_request_n,
	output logic [31:0] ad,
	output logic [3:0] cbe_n,
	output logic port_initiator_ready_n,
	output logic [7:0] sideband_request_port,
	output logic sideband_strobe
);
	logic go_q, sb_q, wdone;
	logic [3:0] k;
	logic [2:0] wcnt;
	logic [1:0] dly;
	wire st_ok = !port_grant_n && grant_status_code == 3'h7;
	wire st_wr = !port_grant_n && grant_status_code[2:1] == 2'h1;
	////////////////////////////////////////
	// enqueue requests, then supply write data
	always_ff @(posedge port_clk) begin
		if (rst) begin
			go_q <= 1'b0;
			k <= 4'h0;
			wcnt <= 3'h0;
			dly <= 2'h0;
			wdone <= 1'b0;
			port_bus_request_n <= 1'b1;
			pipelined_request_n <= 1'b1;
			port_initiator_ready_n <= 1'b1;
			ad <= 32'h0;
			cbe_n <= 4'h0;
		end else begin
			ad <= ~ad; // released lines keep no value
			cbe_n <= ~cbe_n;
			if (go != go_q) begin
				go_q <= go;
				k <= 4'h0;
				port_bus_request_n <= 1'b0;
			end
			if (st_ok && !port_bus_request_n && k < n_req) begin
				pipelined_request_n <= 1'b0;
				ad <= base + {24'h0, k, 4'h0};
				cbe_n <= {2'h0, cmd_pat[2*k +: 2]};
				k <= k + 4'h1;
			end else if (!pipelined_request_n) begin
				pipelined_request_n <= 1'b1;
				port_bus_request_n <= 1'b1;
			end
			if (port_grant_n) begin
				wdone <= 1'b0;
				dly <= 2'h0;
			end else if (st_wr && !wdone && wcnt == 3'h0) begin
				if (dly == lat) begin
					port_initiator_ready_n <= 1'b0;
					ad <= wbase;
					wcnt <= 3'h1;
				end else begin
					dly <= dly + 2'h1;
				end
			end else if (wcnt == 3'h4) begin
				port_initiator_ready_n <= 1'b1;
				wcnt <= 3'h0;
				wdone <= 1'b1;
			end else if (wcnt != 3'h0) begin
				ad <= wbase + {29'h0, wcnt};
				wcnt <= wcnt + 3'h1;
			end
		end
	end
	// one sideband byte per command, strobe low between bytes
	always_ff @(posedge port_clk) begin
		if (rst) begin
			sb_q <= 1'b0;
			sideband_strobe <= 1'b0;
			sideband_request_port <= 8'h0;
		end else if (sb_go != sb_q) begin
			sb_q <= sb_go;
			sideband_request_port <= sb_byte;
			sideband_strobe <= 1'b1;
		end else begin
			sideband_strobe <= 1'b0;
			sideband_request_port <= ~sideband_request_port;
		end
	end
endmodule : ags_master_model

/* File: testbench/tb_ags_grant_port.sv */
// bench for the grant-status and request-enqueue block
// assumes ags_master_model stands on the port side
`timescale 1ns/1ps
module tb_ags_grant_port;
	logic clock = 1'b0, port_clk = 1'b0, rst = 1'b1;
	logic sideband_enable = 1'b0, transfer_2x_mode = 1'b0, read_buffer_full_n = 1'b1;
	logic go = 1'b0, sb_go = 1'b0;
	logic [3:0] n_req = 4'h0;
	logic [1:0] lat = 2'h0;
	logic [7:0] sb_byte = 8'h0, sideband_request_port;
	logic [31:0] base = 32'h0, cmd_pat = 32'h0, wbase = 32'h0, m_ad, port_addr_data_o;
	logic [31:0] last_write_data, beat;
	logic [15:0] enqueued_count, serviced_count, enq_exp = 16'h0, srv_exp = 16'h0;
	logic [2:0] grant_status_code, st_q;
	logic [3:0] m_cbe, port_cmd_byte_en_n_o;
	logic port_grant_n, port_bus_request_n, pipelined_request_n, port_initiator_ready_n;
	logic port_addr_data_oe, port_cmd_byte_en_n_oe, port_target_ready_n_o;
	logic port_target_ready_n_oe, low_lane_data_strobe_o, low_lane_data_strobe_oe;
	logic high_lane_data_strobe_o, high_lane_data_strobe_oe, queue_overflow, sideband_strobe;
	logic g_q = 1'b1;
	logic [35:0] cur;
	logic [35:0] exp_q[$];
	integer seed = 54664;
	int error_cnt = 0, num_checks = 0, r, nn, tcnt = 0;
	wire [31:0] ad_w = port_addr_data_oe ? port_addr_data_o : m_ad;
	wire [3:0] cbe_w = port_cmd_byte_en_n_oe ? port_cmd_byte_en_n_o : m_cbe;
	initial forever #5 clock = ~clock;
	initial begin
		#3;
		forever #80 port_clk = ~port_clk;
	end
	ags_grant_port ags_grant_port_inst (.clock, .rst, .sideband_enable, .transfer_2x_mode,
		.enqueued_count, .serviced_count, .port_clk, .port_grant_n, .grant_status_code,
		.port_bus_request_n, .pipelined_request_n, .read_buffer_full_n,
		.sideband_request_port, .sideband_strobe, .port_addr_data_i(ad_w),
		.port_addr_data_o, .port_addr_data_oe, .port_cmd_byte_en_n_i(cbe_w),
		.port_cmd_byte_en_n_o, .port_cmd_byte_en_n_oe, .port_initiator_ready_n,
		.port_target_ready_n_o, .port_target_ready_n_oe, .low_lane_data_strobe_o,
		.low_lane_data_strobe_oe, .high_lane_data_strobe_o, .high_lane_data_strobe_oe,
		.last_write_data, .queue_overflow);
	ags_master_model ags_master_model_inst (.port_clk, .rst, .go, .n_req, .base, .cmd_pat,
		.wbase, .lat, .sb_go, .sb_byte, .port_grant_n, .grant_status_code,
		.port_bus_request_n, .pipelined_request_n, .ad(m_ad), .cbe_n(m_cbe),
		.port_initiator_ready_n, .sideband_request_port, .sideband_strobe);
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// unknown sideband commands read as low-priority reads
	function automatic logic [35:0] sb_exp(input logic [7:0] b);
		return {(b[7:4] > 4'h3) ? 4'h0 : b[7:4], 25'h0, b[3:0], 3'h0};
	endfunction : sb_exp
	task automatic wait_all;
		int i;
		@(posedge clock);
		for (i = 0; i < 20000 && !(enqueued_count == enq_exp && serviced_count == srv_exp); i++)
			@(posedge clock);
		// hold the batch settings until the last transfer has been checked
		repeat (40) @(posedge clock);
		chk(enqueued_count, enq_exp);
		chk(serviced_count, srv_exp);
	endtask : wait_all
	task automatic batch(input logic [3:0] n, input logic [31:0] pat);
		int j;
		base <= $random(seed);
		wbase <= $random(seed);
		lat <= 2'($random(seed));
		transfer_2x_mode <= 1'($random(seed));
		n_req <= n;
		cmd_pat <= pat;
		@(posedge clock);
		for (j = 0; j < n && j < 8; j++)
			exp_q.push_back({2'h0, pat[2*j +: 2], base + 32'(j * 16)});
		enq_exp <= enq_exp + ((n > 4'h8) ? 16'h8 : {12'h0, n});
		go <= ~go;
	endtask : batch
	// link-side watch: codes, order, read beats, write data
	always @(posedge port_clk) if (!rst) begin
		chk({31'h0, !port_grant_n && grant_status_code inside {[3'h4:3'h6]}}, 0);
		if (!port_grant_n && !g_q)
			chk(grant_status_code, st_q);
		if (!port_grant_n && g_q && grant_status_code != 3'h7) begin
			cur = exp_q.pop_front();
			beat = 0;
			tcnt = 0;
			chk(grant_status_code, cur[34:32]);
		end
		if (port_target_ready_n_oe && !port_target_ready_n_o)
			tcnt = tcnt + 1;
		if (!port_grant_n && grant_status_code[1])
			chk({low_lane_data_strobe_oe, high_lane_data_strobe_oe}, 0);
		if (port_addr_data_oe) begin
			chk(port_addr_data_o, cur[31:0] + beat);
			chk({port_cmd_byte_en_n_oe, port_cmd_byte_en_n_o}, 5'h10);
			chk({low_lane_data_strobe_oe, high_lane_data_strobe_oe,
				low_lane_data_strobe_o, high_lane_data_strobe_o, port_target_ready_n_oe,
				port_target_ready_n_o},
				{{2{transfer_2x_mode}}, {2{transfer_2x_mode & ~beat[0]}}, 2'b10});
			beat = beat + 1;
		end
		if (port_grant_n && !g_q && st_q != 3'h7) begin
			chk(tcnt, 4);
			if (cur[33])
				chk(last_write_data, wbase + 3);
		end
		g_q = port_grant_n;
		st_q = grant_status_code;
	end
	initial begin
		#900000;
		error_cnt++;
		finish_test;
	end
	initial begin
		repeat (140) @(posedge clock);
		rst <= 1'b0;
		repeat (100) @(posedge clock);
		chk({port_grant_n, grant_status_code, queue_overflow}, 5'h1e);
		sb_byte <= 8'h15;
		sb_go <= ~sb_go;
		repeat (100) @(posedge clock);
		chk(enqueued_count, 0);
		sideband_enable <= 1'b1;
		repeat (60) @(posedge clock);
		for (r = 0; r < 4; r++) begin
			sb_byte <= 8'($random(seed));
			@(posedge clock);
			exp_q.push_back(sb_exp(sb_byte));
			sb_go <= ~sb_go;
			enq_exp <= enq_exp + 16'h1;
			srv_exp <= srv_exp + 16'h1;
			wait_all;
		end
		batch(4'h4, 32'he4);
		srv_exp <= srv_exp + 16'h4;
		wait_all;
		chk(queue_overflow, 0);
		for (r = 0; r < 8; r++) begin
			nn = 1 + {$random(seed)} % 8;
			batch(4'(nn), $random(seed));
			srv_exp <= srv_exp + 16'(nn);
			wait_all;
		end
		read_buffer_full_n <= 1'b0;
		batch(4'h9, 32'h0);
		repeat (800) @(posedge clock);
		chk(enqueued_count, enq_exp);
		chk(serviced_count, srv_exp);
		chk(queue_overflow, 1);
		read_buffer_full_n <= 1'b1;
		srv_exp <= srv_exp + 16'h8;
		wait_all;
		finish_test;
	end
endmodule : tb_ags_grant_port
